// ### rtl/chas_pkg.sv
// Package for the channel assigner: register word indices, field layouts,
// reset values, line-channel codes and the packed carriers of the data side.
// Assumes a single 25 MHz clock domain and an Avalon-MM register slave.
package chas_pkg;

  // Register word indices; byte address is four times the index.
  localparam logic [7:0] REG_FIFO_WR_CNT = 8'h04; // Write counter, reads zero.
  localparam logic [7:0] REG_FIFO_RD_CNT = 8'h06; // Read counter, reads zero.
  localparam logic [7:0] REG_FRM_WR_CNT = 8'h0c; // Frame write counter, reads zero.
  localparam logic [7:0] REG_FRM_RD_CNT = 8'h0d; // Frame read counter, reads zero.
  localparam logic [7:0] REG_INC_RESET = 8'h0e; // Increment and reset strobe, write only.
  localparam logic [7:0] REG_FIFO_SELECT = 8'h0f; // FIFO number and direction.
  localparam logic [7:0] REG_SLOT_SELECT = 8'h10; // PCM slot number and direction.
  localparam logic [7:0] REG_FIFO_MODE = 8'h11; // Flow mode field.
  localparam logic [7:0] REG_SEQ_INDEX = 8'h12; // Sequence list index.
  localparam logic [7:0] REG_DATA_PORT = 8'h80; // Data port, reads zero here.
  localparam logic [7:0] REG_DATA_NOINC = 8'h84; // Data port without increment.
  localparam logic [7:0] REG_SLOT_ROUTE = 8'hd0; // Slot route configuration entry.
  localparam logic [7:0] REG_MASK_BYTE = 8'hf4; // Subchannel mask byte.
  localparam logic [7:0] REG_CONN_CFG = 8'hfa; // FIFO connection configuration.
  localparam logic [7:0] REG_SUBCH_CFG = 8'hfb; // Subchannel configuration.
  localparam logic [7:0] REG_CHAN_ASSIGN = 8'hfc; // FIFO to channel assignment.
  localparam logic [7:0] REG_SEQ_ENTRY = 8'hfd; // FIFO sequence entry.
  localparam logic [7:0] REG_FIFO_CTRL = 8'hff; // FIFO control.

  // Field positions.
  localparam int SEL_DIR_BIT = 0; // Direction bit of both select registers.
  localparam int FIFO_NUM_LSB = 1; // FIFO number, four bits.
  localparam int SLOT_NUM_LSB = 1; // Slot number, five bits.
  localparam int ROUTE_NUM_LSB = 1; // Channel number in a slot entry, four bits.
  localparam int IRQ_LSB = 2; // Interrupt-select field, three bits.

  // Flow mode encodings of the two-bit field.
  localparam logic [1:0] FLOW_SIMPLE = 2'h0; // Simple flow mode.
  localparam logic [1:0] FLOW_CHAN_SEL = 2'h1; // Channel select flow mode.
  localparam logic [1:0] FLOW_SEQUENCE = 2'h2; // Sequence flow mode.

  // Sizes and reset value.
  localparam int MAX_FIFO = 16; // Largest FIFO count the storage holds.
  localparam int MAX_SLOT = 32; // Largest slot count the storage holds.
  localparam logic [7:0] CFG_RESET = 8'h00; // Reset value of every entry.
  localparam logic DIR_TX = 1'b0; // Transmit direction code.
  localparam logic DIR_RX = 1'b1; // Receive direction code.

  // Line interface channel codes.
  typedef enum logic [2:0] {LINE_NONE, LINE_B1, LINE_B2, LINE_D, LINE_AUX, LINE_E} chas_line_e;

  // PCM byte arriving on or requested for a slot.
  typedef struct packed {
    logic valid; // Byte present this cycle.
    logic [4:0] slot; // Slot number.
    logic [7:0] data; // Slot byte.
  } chas_pcm_s;

  // Byte offered by a FIFO to the flow controller.
  typedef struct packed {
    logic valid; // Byte present this cycle.
    logic [3:0] num; // FIFO number.
    logic dir; // FIFO direction.
    logic [7:0] data; // FIFO byte.
  } chas_fifo_s;

  // Processed FIFO byte with its channel and line target.
  typedef struct packed {
    logic valid; // One-cycle pulse.
    logic [3:0] chan; // Switching channel.
    chas_line_e line; // Line channel of that switching channel.
    logic [3:0] bits; // Number of bits that carry data.
    logic [7:0] data; // Byte after mask merge.
  } chas_proc_s;

  // Byte passed from a PCM slot to the line interface.
  typedef struct packed {
    logic valid; // One-cycle pulse.
    chas_line_e line; // Line channel.
    logic [7:0] data; // Byte.
  } chas_line_s;

  // Fixed map from switching channel and direction to line channel.
  function automatic chas_line_e chas_line_map(input logic [3:0] chan, input logic dir);
    unique case (chan)
      4'h0: chas_line_map = LINE_B1;
      4'h1: chas_line_map = LINE_B2;
      4'h2: chas_line_map = LINE_D;
      4'h3: chas_line_map = (dir == DIR_TX) ? LINE_AUX : LINE_E;
      default: chas_line_map = LINE_NONE;
    endcase
  endfunction : chas_line_map

endpackage : chas_pkg

// ### rtl/chas_router.sv
// Channel assigner: PCM slot assigner, fixed line map, FIFO to channel assigner,
// flow-mode dependent indexing and subchannel mask merge behind an Avalon-MM slave.
// Assumes inputs synchronous to clk_i and an Avalon master that holds its request.
//
// Functional notes
// - Any slot connects to any channel.
// - Slot select, then route entry stores channel.
// - Slot array accesses follow current slot select.
// - Looped slots pass through channel switching buffer.
// - Line map is fixed per channel.
// - Three flow modes steer assigner and subchannels.
// - Flow field zero selects simple mode.
// - Simple mode indexes arrays by FIFO select.
// - Simple mode channel equals FIFO number.
// - Simple mode gives one-to-one connections only.
// - PCM-to-line bypass needs enabled FIFO.
// - PCM-to-PCM loop needs no enabled FIFO.
// - Sequence mode indexes three arrays by list.
// - Masked bits replaced from per-channel mask byte.
// - Software enables subchannels for D and E.
// - Transparent byte rate stays, useful bits shrink.
// - HDLC rate scales with unmasked bit count.
// - One channel processed per FIFO byte.
// - Nonzero interrupt-select field enables FIFO path.
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/100ps
module chas_router #(
  parameter int NUM_FIFO = 16, // Number of FIFOs per direction.
  parameter int NUM_SLOT = 32 // Number of PCM slots per direction.
) (
  input wire logic clk_i, // Clock, 25 MHz.
  input wire logic rst_b_i, // Synchronous reset, active low.
  input wire logic ce_i, // Clock enable, freezes all state when low.
  input wire logic [7:0] address_i, // Avalon word address.
  input wire logic read_i, // Avalon read.
  input wire logic write_i, // Avalon write.
  input wire logic [31:0] writedata_i, // Avalon write data.
  input wire logic [3:0] byteenable_i, // Avalon byte enables.
  output logic [31:0] readdata_o, // Avalon read data, registered.
  output logic waitrequest_o, // Avalon wait request.
  input wire chas_pkg::chas_pcm_s pcm_rx_i, // Byte received on a slot.
  input wire chas_pkg::chas_pcm_s pcm_tx_i, // Request for a transmit slot byte.
  output chas_pkg::chas_pcm_s pcm_tx_o, // Byte for the transmit slot, registered.
  input wire chas_pkg::chas_fifo_s fifo_i, // Byte offered by a FIFO.
  output chas_pkg::chas_proc_s proc_o, // Processed FIFO byte, registered.
  output chas_pkg::chas_line_s line_o // PCM byte forwarded to the line, registered.
);
  import chas_pkg::*;

  // Refuse sizes the storage cannot hold.
  if (NUM_FIFO < 1 || NUM_FIFO > MAX_FIFO || NUM_SLOT < 1 || NUM_SLOT > MAX_SLOT)
  begin : g_size_check
    $error("chas_router: FIFO or slot count out of range");
  end

  // All state of the block.
  typedef struct packed {
    logic ack; // Bus answer phase.
    logic [7:0] rdata; // Read data held for the bus.
    logic [7:0] fifo_sel; // FIFO select register.
    logic [7:0] slot_sel; // Slot select register.
    logic [1:0] flow; // Flow mode field.
    logic [7:0] seq_idx; // Sequence list index.
    logic [2*MAX_SLOT-1:0][4:0] slot_cfg; // Slot route entries.
    logic [2*MAX_FIFO-1:0][7:0] con_cfg; // Connection entries.
    logic [2*MAX_FIFO-1:0][7:0] sub_cfg; // Subchannel entries.
    logic [2*MAX_FIFO-1:0][7:0] chan_asg; // Channel assignment entries.
    logic [2*MAX_FIFO-1:0][7:0] seq_ent; // Sequence entries.
    logic [2*MAX_FIFO-1:0][7:0] ctrl; // FIFO control entries.
    logic [2*MAX_FIFO-1:0][7:0] msk; // Mask bytes, one per channel and direction.
    logic [MAX_FIFO-1:0][7:0] sw_buf; // PCM receive switching buffers.
    chas_pcm_s pcm_tx; // Transmit slot output.
    chas_proc_s proc; // Processed FIFO output.
    chas_line_s line; // Line output.
  } chas_state_s;

  chas_state_s s; // Registered state.
  chas_state_s next_s; // Next state.
  chas_state_s rst_s; // Reset image.

  logic req; // A bus request is present.
  logic [4:0] fidx; // Entry index from FIFO select.
  logic fidx_ok; // FIFO select names an existing FIFO.
  logic [4:0] aidx; // Index for subchannel, channel and sequence arrays.
  logic aidx_ok; // That index names an existing FIFO.
  logic [5:0] sidx; // Entry index from slot select.
  logic sidx_ok; // Slot select names an existing slot.
  logic [7:0] rd_val; // Read multiplexer output.
  logic [4:0] f_idx; // Entry of the FIFO offering a byte.
  logic f_en; // That FIFO is enabled.
  logic [3:0] f_ch; // Channel for that FIFO byte.
  logic [7:0] f_cfg; // Subchannel selection for it.
  logic [7:0] f_msk; // Mask byte of its channel.
  logic [7:0] f_merged; // Byte after mask merge.
  logic [3:0] f_bits; // Count of data-carrying bits.
  logic [3:0] rx_ch; // Channel of the receive slot.
  logic rx_ok; // Receive slot exists.
  logic [3:0] tx_ch; // Channel of the transmit slot.
  logic [4:0] line_idx; // Transmit FIFO entry of the receive slot channel.
  logic line_en; // Line bypass allowed for that channel.

  // Index decode; sequence mode moves three arrays to the list index.
  assign req = read_i | write_i;
  assign fidx = {s.fifo_sel[FIFO_NUM_LSB+:4], s.fifo_sel[SEL_DIR_BIT]};
  assign fidx_ok = 32'(s.fifo_sel[FIFO_NUM_LSB+:4]) < NUM_FIFO;
  assign aidx = (s.flow == FLOW_SEQUENCE) ? s.seq_idx[4:0] : fidx;
  assign aidx_ok = (s.flow == FLOW_SEQUENCE) ? (32'(s.seq_idx[4:1]) < NUM_FIFO) : fidx_ok;
  assign sidx = {s.slot_sel[SLOT_NUM_LSB+:5], s.slot_sel[SEL_DIR_BIT]};
  assign sidx_ok = 32'(s.slot_sel[SLOT_NUM_LSB+:5]) < NUM_SLOT;

  // FIFO path decode: enable, channel choice and mask merge.
  assign f_idx = {fifo_i.num, fifo_i.dir};
  assign f_en = (32'(fifo_i.num) < NUM_FIFO) && (s.con_cfg[f_idx][IRQ_LSB+:3] != 3'h0);
  assign f_ch = (s.flow == FLOW_SIMPLE) ? fifo_i.num : s.chan_asg[f_idx][3:0];
  assign f_cfg = s.sub_cfg[f_idx];
  assign f_msk = s.msk[{f_ch, fifo_i.dir}];
  assign f_merged = (f_cfg == CFG_RESET) ? fifo_i.data
                  : ((fifo_i.data & f_cfg) | (f_msk & ~f_cfg));

  // Count of bits that carry FIFO data, for HDLC rate scaling.
  always_comb
  begin
    f_bits = 4'h0;
    for (int i = 0; i < 8; i++)
    begin
      f_bits = f_bits + {3'h0, f_cfg[i]};
    end
    if (f_cfg == CFG_RESET)
    begin
      f_bits = 4'h8; // All bits carry data when no selection is set.
    end
  end

  // Slot path decode; the slot entry gives the channel for any slot.
  assign rx_ch = s.slot_cfg[{pcm_rx_i.slot, DIR_RX}][ROUTE_NUM_LSB+:4];
  assign rx_ok = 32'(pcm_rx_i.slot) < NUM_SLOT;
  assign tx_ch = s.slot_cfg[{pcm_tx_i.slot, DIR_TX}][ROUTE_NUM_LSB+:4];
  assign line_idx = {rx_ch, DIR_TX};
  assign line_en = (32'(rx_ch) < NUM_FIFO) && (s.con_cfg[line_idx][IRQ_LSB+:3] != 3'h0);

  // Read multiplexer; counters and data ports read zero, unmapped reads zero.
  always_comb
  begin
    rd_val = 8'h00;
    unique case (address_i)
      REG_FIFO_SELECT: rd_val = s.fifo_sel;
      REG_SLOT_SELECT: rd_val = s.slot_sel;
      REG_FIFO_MODE: rd_val = {6'h00, s.flow};
      REG_SEQ_INDEX: rd_val = s.seq_idx;
      REG_SLOT_ROUTE: rd_val = sidx_ok ? {3'h0, s.slot_cfg[sidx]} : 8'h00;
      REG_MASK_BYTE: rd_val = fidx_ok ? s.msk[fidx] : 8'h00;
      REG_CONN_CFG: rd_val = fidx_ok ? s.con_cfg[fidx] : 8'h00;
      REG_SUBCH_CFG: rd_val = aidx_ok ? s.sub_cfg[aidx] : 8'h00;
      REG_CHAN_ASSIGN: rd_val = aidx_ok ? s.chan_asg[aidx] : 8'h00;
      REG_SEQ_ENTRY: rd_val = aidx_ok ? s.seq_ent[aidx] : 8'h00;
      REG_FIFO_CTRL: rd_val = fidx_ok ? s.ctrl[fidx] : 8'h00;
      default: rd_val = 8'h00;
    endcase
  end

  // Reset image: every entry at its reset configuration.
  always_comb
  begin
    rst_s = '0;
    rst_s.proc.line = LINE_NONE;
    rst_s.line.line = LINE_NONE;
  end

  // Next state: bus slave, register writes and the data side.
  always_comb
  begin
    next_s = s;
    // Answer one cycle after the request appears.
    next_s.ack = req & ~s.ack;
    if (read_i && !s.ack)
    begin
      next_s.rdata = rd_val; // Held until the master samples it.
    end
    // Writes take effect at the edge where waitrequest is seen low.
    if (write_i && s.ack && byteenable_i[0])
    begin
      unique case (address_i)
        REG_FIFO_SELECT: next_s.fifo_sel = writedata_i[7:0];
        REG_SLOT_SELECT: next_s.slot_sel = writedata_i[7:0];
        REG_FIFO_MODE: next_s.flow = writedata_i[1:0];
        REG_SEQ_INDEX: next_s.seq_idx = writedata_i[7:0];
        REG_SLOT_ROUTE:
        begin
          if (sidx_ok)
          begin
            next_s.slot_cfg[sidx] = writedata_i[4:0];
          end
        end
        REG_MASK_BYTE:
        begin
          if (fidx_ok)
          begin
            next_s.msk[fidx] = writedata_i[7:0];
          end
        end
        REG_CONN_CFG:
        begin
          if (fidx_ok)
          begin
            next_s.con_cfg[fidx] = writedata_i[7:0];
          end
        end
        REG_SUBCH_CFG:
        begin
          if (aidx_ok)
          begin
            next_s.sub_cfg[aidx] = writedata_i[7:0];
          end
        end
        REG_CHAN_ASSIGN:
        begin
          // Ignored in simple mode where the channel follows the FIFO.
          if (aidx_ok && s.flow != FLOW_SIMPLE)
          begin
            next_s.chan_asg[aidx] = writedata_i[7:0];
          end
        end
        REG_SEQ_ENTRY:
        begin
          if (aidx_ok)
          begin
            next_s.seq_ent[aidx] = writedata_i[7:0];
          end
        end
        REG_FIFO_CTRL:
        begin
          if (fidx_ok)
          begin
            next_s.ctrl[fidx] = writedata_i[7:0];
          end
        end
        default:
        begin
          // Read-only, strobe-only and unmapped words accept and drop the write.
        end
      endcase
    end
    // Receive slot byte lands in its channel's switching buffer.
    next_s.line.valid = 1'b0;
    if (pcm_rx_i.valid && rx_ok)
    begin
      next_s.sw_buf[rx_ch] = pcm_rx_i.data;
      // Bypass to the line only through an enabled transmit FIFO entry.
      next_s.line.valid = line_en && (chas_line_map(rx_ch, DIR_TX) != LINE_NONE);
      next_s.line.line = chas_line_map(rx_ch, DIR_TX);
      next_s.line.data = pcm_rx_i.data;
    end
    // Transmit slot reads the buffer of its channel.
    next_s.pcm_tx.valid = pcm_tx_i.valid && (32'(pcm_tx_i.slot) < NUM_SLOT);
    next_s.pcm_tx.slot = pcm_tx_i.slot;
    next_s.pcm_tx.data = s.sw_buf[tx_ch];
    // One FIFO byte gives one channel byte per cycle.
    next_s.proc.valid = fifo_i.valid && f_en;
    if (fifo_i.valid && f_en)
    begin
      next_s.proc.chan = f_ch;
      next_s.proc.line = chas_line_map(f_ch, fifo_i.dir);
      next_s.proc.bits = f_bits;
      next_s.proc.data = f_merged;
    end
  end

  // State register with synchronous reset and clock enable.
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      s <= rst_s;
    end
    else if (ce_i)
    begin
      s <= next_s;
    end
  end

  // Outputs come straight from state, waitrequest from the answer phase.
  assign waitrequest_o = req & ~s.ack;
  assign readdata_o = {24'h000000, s.rdata};
  assign pcm_tx_o = s.pcm_tx;
  assign proc_o = s.proc;
  assign line_o = s.line;

  // Accepted register write to a given word.
  sequence bus_wr(logic [7:0] addr);
    ce_i && write_i && s.ack && byteenable_i[0] && address_i == addr;
  endsequence

  // First cycle of a read of a given word.
  sequence bus_rd(logic [7:0] addr);
    ce_i && read_i && !s.ack && address_i == addr;
  endsequence

  a_bus_one_wait: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && req && waitrequest_o ##1 req |-> !waitrequest_o)
    else $error("waitrequest stayed high a second cycle");
  a_slot_route_store: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    bus_wr(REG_SLOT_ROUTE) ##0 sidx_ok |=> s.slot_cfg[$past(sidx)] == $past(writedata_i[4:0]))
    else $error("slot route entry not stored");
  a_slot_index_read: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    bus_rd(REG_SLOT_ROUTE) ##0 sidx_ok |=> readdata_o[4:0] == s.slot_cfg[$past(sidx)])
    else $error("slot route read from wrong entry");
  a_pcm_loop_path: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && pcm_rx_i.valid && rx_ok ##1 ce_i && pcm_tx_i.valid && tx_ch == $past(rx_ch)
    && !(pcm_rx_i.valid && rx_ok && rx_ch == tx_ch)
    |=> pcm_tx_o.data == $past(pcm_rx_i.data, 2))
    else $error("looped slot byte lost");
  a_line_map_fixed: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && fifo_i.valid && f_en && f_ch == 4'h3 && fifo_i.dir == DIR_RX |=> proc_o.line == LINE_E)
    else $error("channel 3 receive not mapped to E");
  a_simple_chan_eq: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && s.flow == FLOW_SIMPLE && fifo_i.valid && f_en |=> proc_o.chan == $past(fifo_i.num))
    else $error("simple mode channel differs from FIFO");
  a_fsm_list_index: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    bus_wr(REG_SUBCH_CFG) ##0 (s.flow == FLOW_SEQUENCE && aidx_ok)
    |=> s.sub_cfg[$past(s.seq_idx[4:0])] == $past(writedata_i[7:0]))
    else $error("sequence mode write missed list index");
  a_mask_merge: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && fifo_i.valid && f_en && f_cfg != CFG_RESET
    |=> proc_o.data == (($past(fifo_i.data) & $past(f_cfg)) | ($past(f_msk) & ~$past(f_cfg))))
    else $error("mask merge wrong");
  a_enable_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && fifo_i.valid && !f_en |=> !proc_o.valid)
    else $error("disabled FIFO produced a byte");
  a_bypass_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && pcm_rx_i.valid && !line_en |=> !line_o.valid)
    else $error("line bypass without enabled FIFO");
  // A bypassed byte on channel 0 must land on the B1 line channel.
  a_bypass_b1_map: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && pcm_rx_i.valid && rx_ok && rx_ch == 4'h0 && line_en
    |=> line_o.valid && line_o.line == LINE_B1)
    else $error("channel 0 bypass not mapped to B1");
  // In simple mode a channel assignment write must leave every entry alone.
  a_simple_assign_fixed: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    bus_wr(REG_CHAN_ASSIGN) ##0 s.flow == FLOW_SIMPLE |=> $stable(s.chan_asg))
    else $error("channel assignment written in simple mode");

endmodule : chas_router

// ### verif/chas_pcm_model.sv
// PCM highway model: offers received slot bytes and asks for transmit bytes.
// Assumes the router samples its data inputs on the rising edge of clk_i.
`timescale 1ns/100ps
module chas_pcm_model
  import chas_pkg::*;
(
  input wire logic clk_i, // Clock.
  output chas_pkg::chas_pcm_s rx_o, // Received slot byte.
  output chas_pkg::chas_pcm_s tx_o // Transmit slot request.
);
  // The highway is idle until the bench asks for traffic.
  initial
  begin
    rx_o = '0;
    tx_o = '0;
  end
  // Offers one byte for one cycle; afterwards the lines show stale inverted values.
  task automatic send_rx(input logic [4:0] slot, input logic [7:0] data);
    @(posedge clk_i);
    rx_o <= '{1'b1, slot, data};
    @(posedge clk_i);
    rx_o <= '{1'b0, ~slot, ~data};
  endtask : send_rx
  // Asks for one transmit byte at once; call it right after a rising edge.
  // The data field carries no meaning here.
  task automatic ask_tx(input logic [4:0] slot);
    tx_o <= '{1'b1, slot, 8'h5a};
    @(posedge clk_i);
    tx_o <= '{1'b0, ~slot, 8'ha5};
  endtask : ask_tx
endmodule : chas_pcm_model

// ### verif/testbench.sv
// Self-checking bench for the channel assigner with an Avalon master.
// Assumes one 25 MHz clock and the PCM highway model beside the router.
`timescale 1ns/100ps
module testbench;
  import chas_pkg::*;
  logic clk = 1'b0; // Bench clock.
  logic rst_b = 1'b0; // Synchronous reset, active low.
  logic [7:0] address = 8'h00; // Word address.
  logic read = 1'b0; // Read strobe.
  logic write = 1'b0; // Write strobe.
  logic [31:0] writedata = '0; // Write data.
  logic [31:0] readdata; // Read data.
  logic waitrequest; // Slave stall.
  chas_pcm_s pcm_rx, pcm_tx, pcm_out; // PCM side.
  chas_fifo_s fifo = '0; // FIFO byte offer.
  chas_proc_s proc; // Processed byte.
  chas_line_s line; // Line byte.
  int num_errors = 0; // Mismatches.
  int checks_done = 0; // Comparisons.
  int cycles = 0; // Timeout counter.
  logic [7:0] rd; // Last read value.
  always #20 clk = ~clk;
  chas_router #(.NUM_FIFO(8), .NUM_SLOT(32)) uut (.clk_i(clk), .rst_b_i(rst_b), .ce_i(1'b1),
    .address_i(address), .read_i(read), .write_i(write), .writedata_i(writedata),
    .byteenable_i(4'h1), .readdata_o(readdata), .waitrequest_o(waitrequest),
    .pcm_rx_i(pcm_rx), .pcm_tx_i(pcm_tx), .pcm_tx_o(pcm_out), .fifo_i(fifo),
    .proc_o(proc), .line_o(line));
  chas_pcm_model pcm (.clk_i(clk), .rx_o(pcm_rx), .tx_o(pcm_tx));
  // Prints the counts and the verdict, then stops.
  task automatic complete_run;
    $display("TB: errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  // Compares one byte-wide result.
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t byte got %h expected %h", $time, got, exp);
    end
  endtask : check_byte
  // Compares one flag.
  task automatic check_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask : check_flag
  // One Avalon access, held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    address <= addr;
    writedata <= {24'h0, data};
    write <= wr;
    read <= ~wr;
    @(posedge clk);
    while (waitrequest !== 1'b0)
    begin
      @(posedge clk);
    end
    rd = readdata[7:0];
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    bus(1'b1, addr, data);
  endtask : wr
  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    bus(1'b0, addr, 8'h00);
    check_byte(rd, exp);
  endtask : rd_chk
  // Offers one FIFO byte and lets the answer edge pass.
  task automatic fifo_byte(input logic [3:0] num, input logic dir, input logic [7:0] data);
    @(posedge clk);
    fifo <= '{1'b1, num, dir, data};
    @(posedge clk);
    fifo <= '{1'b0, ~num, ~dir, ~data};
    #1;
  endtask : fifo_byte
  // Reset values, a read-only counter and an unmapped word.
  task automatic t_reset;
    rd_chk(REG_SLOT_SELECT, CFG_RESET);
    rd_chk(REG_FIFO_MODE, CFG_RESET);
    rd_chk(REG_CONN_CFG, CFG_RESET);
    wr(REG_FIFO_WR_CNT, 8'h33);
    rd_chk(REG_FIFO_WR_CNT, 8'h00);
    rd_chk(8'h01, 8'h00);
  endtask : t_reset
  // Every flow mode, then list indexing in sequence mode and fixed channels in simple mode.
  task automatic t_modes;
    for (int m = 0; m < 3; m++)
    begin
      wr(REG_FIFO_MODE, 8'(m));
      rd_chk(REG_FIFO_MODE, 8'(m));
    end
    wr(REG_SEQ_INDEX, 8'h05);
    wr(REG_SUBCH_CFG, 8'h55);
    wr(REG_SEQ_ENTRY, 8'h4b);
    wr(REG_FIFO_SELECT, 8'h06);
    wr(REG_FIFO_CTRL, 8'h2d);
    rd_chk(REG_SEQ_INDEX, 8'h05);
    wr(REG_FIFO_MODE, {6'h0, FLOW_SIMPLE});
    wr(REG_FIFO_SELECT, 8'h05);
    rd_chk(REG_SUBCH_CFG, 8'h55);
    rd_chk(REG_SEQ_ENTRY, 8'h4b);
    rd_chk(REG_FIFO_CTRL, 8'h00);
    wr(REG_SUBCH_CFG, 8'h00);
    wr(REG_FIFO_SELECT, 8'h04);
    rd_chk(REG_SUBCH_CFG, 8'h00);
    wr(REG_CHAN_ASSIGN, 8'h05);
    rd_chk(REG_CHAN_ASSIGN, 8'h00);
    wr(REG_FIFO_SELECT, 8'h06);
    rd_chk(REG_FIFO_CTRL, 8'h2d);
  endtask : t_modes
  // Fixed line map of channels 0 to 3; channel equals FIFO number.
  task automatic t_line_map;
    chas_line_e exp_line [5] = '{LINE_B1, LINE_B2, LINE_D, LINE_AUX, LINE_E};
    for (int n = 0; n < 5; n++)
    begin
      wr(REG_FIFO_SELECT, (n == 4) ? 8'h07 : 8'(n << 1));
      wr(REG_CONN_CFG, 8'h1c);
      fifo_byte((n == 4) ? 4'h3 : 4'(n), n == 4, 8'h3c);
      check_flag(proc.valid, 1'b1);
      check_byte({4'h0, proc.chan}, (n == 4) ? 8'h03 : 8'(n));
      check_byte({5'h0, proc.line}, {5'h0, exp_line[n]});
      check_byte(proc.data, 8'h3c);
    end
    fifo_byte(4'h4, DIR_TX, 8'h11);
    check_flag(proc.valid, 1'b0);
    fifo_byte(4'h9, DIR_TX, 8'h11);
    check_flag(proc.valid, 1'b0);
  endtask : t_line_map
  // Two data bits per byte with the rest taken from the mask byte.
  task automatic t_subch;
    wr(REG_FIFO_SELECT, 8'h04);
    wr(REG_SUBCH_CFG, 8'h03);
    wr(REG_MASK_BYTE, 8'hf0);
    rd_chk(REG_MASK_BYTE, 8'hf0);
    fifo_byte(4'h2, DIR_TX, 8'h0f);
    check_byte(proc.data, 8'hf3);
    check_byte({4'h0, proc.bits}, 8'h02);
    wr(REG_SUBCH_CFG, 8'h00);
  endtask : t_subch
  // Slot loop through channel 12, above the FIFO count, so no FIFO serves that channel.
  task automatic t_slots;
    wr(REG_SLOT_SELECT, 8'h0b);
    wr(REG_SLOT_ROUTE, 8'h19);
    wr(REG_SLOT_SELECT, 8'h12);
    wr(REG_SLOT_ROUTE, 8'h18);
    wr(REG_SLOT_SELECT, 8'h0b);
    rd_chk(REG_SLOT_ROUTE, 8'h19);
    pcm.send_rx(5'h05, 8'ha5);
    pcm.ask_tx(5'h09);
    #1;
    check_flag(pcm_out.valid, 1'b1);
    check_byte(pcm_out.data, 8'ha5);
    check_byte({3'h0, pcm_out.slot}, 8'h09);
  endtask : t_slots
  // Slot to line bypass passes only while the channel's transmit FIFO is enabled.
  task automatic t_pcm_line;
    wr(REG_SLOT_SELECT, 8'h03);
    wr(REG_SLOT_ROUTE, 8'h01);
    pcm.send_rx(5'h01, 8'h96);
    #1;
    check_flag(line.valid, 1'b1);
    check_byte({line.line, line.data[4:0]}, {LINE_B1, 5'h16});
    check_byte(line.data, 8'h96);
    wr(REG_FIFO_SELECT, 8'h00);
    wr(REG_CONN_CFG, 8'h00);
    pcm.send_rx(5'h01, 8'h69);
    #1;
    check_flag(line.valid, 1'b0);
  endtask : t_pcm_line
  // A hang is cut short after a generous cycle count.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      num_errors++;
      complete_run();
    end
  end
  // Main sequence.
  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_modes();
    t_line_map();
    t_subch();
    t_slots();
    t_pcm_line();
    complete_run();
  end
endmodule : testbench
